/* File: rtl/cirq_pkg.sv */
// Package of the interrupt request and enable block: register indices, field positions,
// reset values and the state carrier.
// Assumes a 32-bit APB master and event sources that run on the block's own clock.

package cirq_pkg;

	localparam logic [7:0] CIRQ_IDX_MAIN_EN  = 8'h02;
	localparam logic [7:0] CIRQ_IDX_AUX_EN   = 8'h03;
	localparam logic [7:0] CIRQ_IDX_MAIN_REQ = 8'h04;
	localparam logic [7:0] CIRQ_IDX_AUX_REQ  = 8'h05;
	localparam logic [7:0] CIRQ_IDX_STATUS   = 8'h07;
	localparam logic [7:0] CIRQ_IDX_OPTION   = 8'h11;
	localparam int         CIRQ_ADDR_W       = 10;

	localparam logic [7:0] CIRQ_MAIN_EN_RST  = 8'h80;
	localparam logic [7:0] CIRQ_AUX_EN_RST   = 8'h00;
	localparam logic [6:0] CIRQ_MAIN_REQ_RST = 7'h14;
	localparam logic [4:0] CIRQ_AUX_REQ_RST  = 5'h00;
	localparam logic [7:0] CIRQ_AUX_EN_MASK  = 8'h9F;

	localparam int CIRQ_SET_SEL    = 7;
	localparam int CIRQ_DRIVE_SEL  = 7;
	localparam int CIRQ_INVERT     = 7;
	localparam int CIRQ_TX_DONE    = 6;
	localparam int CIRQ_RX_DONE    = 5;
	localparam int CIRQ_CMD_IDLE   = 4;
	localparam int CIRQ_FIFO_HIGH  = 3;
	localparam int CIRQ_FIFO_LOW   = 2;
	localparam int CIRQ_FAULT      = 1;
	localparam int CIRQ_CNT_ZERO   = 0;
	localparam int CIRQ_SEC_EDGE   = 4;
	localparam int CIRQ_MODE_FOUND = 3;
	localparam int CIRQ_CSUM_DONE  = 2;
	localparam int CIRQ_FIELD_ON   = 1;
	localparam int CIRQ_FIELD_OFF  = 0;
	localparam int CIRQ_STAT_IRQ   = 4;
	localparam int CIRQ_STAT_ARMED = 0;

	typedef struct packed {
		logic [7:0]  aux_en;
		logic [7:0]  main_en;
		logic [6:0]  main_req;
		logic [4:0]  aux_req;
		logic        receive_clean_only;
		logic        det_armed;
		logic [2:0]  sec_sync;
		logic        fifo_high_d;
		logic        fifo_low_d;
		logic        field_d;
		logic [31:0] prdata;
		logic        pready;
		logic        pslverr;
		logic        irq_out;
		logic        irq_oe;
	} cirq_state_t;

	typedef struct packed {
		logic tx_last_bit;
		logic rx_valid_end;
		logic fifo_has_data;
		logic cmd_self_end;
		logic cmd_unknown;
		logic fifo_high_status;
		logic fifo_low_status;
		logic error_any;
		logic countdown_zero;
		logic mode_detected;
		logic auto_anticollision_cmd;
		logic rf_reset;
		logic checksum_cmd_active;
		logic checksum_all_done;
		logic field_present;
	} cirq_events_t;

endpackage

/* File: rtl/cirq_core.sv */
// Interrupt request and enable logic with an APB register slave and the interrupt pin.
// Assumes all events arrive on clk_i; only the secure signal input comes from a pin.
//
// The implementer's own choice: register access over APB.
`timescale 1ns/1ps

module cirq_core
	import cirq_pkg::*;
(
	input  wire logic                   clk_i,
	input  wire logic                   sys_rst_i,
	input  wire logic                   ce_i,
	input  wire logic                   psel_i,
	input  wire logic                   penable_i,
	input  wire logic                   pwrite_i,
	input  wire logic [CIRQ_ADDR_W-1:0] paddr_i,
	input  wire logic [31:0]            pwdata_i,
	output logic      [31:0]            prdata_o,
	output logic                        pready_o,
	output logic                        pslverr_o,
	input  wire cirq_events_t           events_i,
	input  wire logic                   secure_signal_input_i,
	output logic                        irq_o,
	output logic                        irq_oe_o
);

	// ****************************************************************
	// State and next state
	// ****************************************************************
	cirq_state_t st;
	cirq_state_t next_st;

	logic       wr_take;
	logic       rd_setup;
	logic [7:0] idx;
	logic       idx_ok;
	logic [6:0] main_hw;
	logic [4:0] aux_hw;
	logic [6:0] main_set;
	logic [6:0] main_clr;
	logic [4:0] aux_set;
	logic [4:0] aux_clr;
	logic       combined;
	logic       level;
	logic       main_wr;
	logic       aux_wr;
	logic [6:0] main_kept;
	logic [4:0] aux_kept;

	assign idx      = paddr_i[9:2];
	assign idx_ok   = (paddr_i[1:0] == 2'h0) &&
		(idx == CIRQ_IDX_MAIN_EN || idx == CIRQ_IDX_AUX_EN || idx == CIRQ_IDX_MAIN_REQ ||
		 idx == CIRQ_IDX_AUX_REQ || idx == CIRQ_IDX_STATUS || idx == CIRQ_IDX_OPTION);
	// Writes land only at the edge where the access phase sees pready.
	assign wr_take  = psel_i && penable_i && st.pready && pwrite_i;
	assign rd_setup = psel_i && !penable_i;
	assign main_wr   = wr_take && idx_ok && idx == CIRQ_IDX_MAIN_REQ;
	assign aux_wr    = wr_take && idx_ok && idx == CIRQ_IDX_AUX_REQ;
	assign main_kept = st.main_req & ~pwdata_i[6:0];
	assign aux_kept  = st.aux_req & ~pwdata_i[4:0];

	// ****************************************************************
	// Hardware set sources
	// ****************************************************************
	always_comb begin
		main_hw = 7'h00;
		aux_hw  = 5'h00;
		main_hw[CIRQ_TX_DONE]   = events_i.tx_last_bit;
		main_hw[CIRQ_RX_DONE]   = events_i.rx_valid_end &&
			(!st.receive_clean_only || events_i.fifo_has_data);
		// A host-issued idle does not arrive as a self end, so it sets nothing.
		main_hw[CIRQ_CMD_IDLE]  = events_i.cmd_self_end || events_i.cmd_unknown;
		main_hw[CIRQ_FIFO_HIGH] = events_i.fifo_high_status && !st.fifo_high_d;
		main_hw[CIRQ_FIFO_LOW]  = events_i.fifo_low_status && !st.fifo_low_d;
		main_hw[CIRQ_FAULT]     = events_i.error_any;
		main_hw[CIRQ_CNT_ZERO]  = events_i.countdown_zero;
		aux_hw[CIRQ_SEC_EDGE]   = st.sec_sync[1] ^ st.sec_sync[2];
		aux_hw[CIRQ_MODE_FOUND] = events_i.mode_detected && st.det_armed;
		aux_hw[CIRQ_CSUM_DONE]  = events_i.checksum_cmd_active &&
			events_i.checksum_all_done;
		aux_hw[CIRQ_FIELD_ON]   = events_i.field_present && !st.field_d;
		aux_hw[CIRQ_FIELD_OFF]  = !events_i.field_present && st.field_d;
	end

	// ****************************************************************
	// Software set and clear masks
	// ****************************************************************
	always_comb begin
		main_set = 7'h00;
		main_clr = 7'h00;
		aux_set  = 5'h00;
		aux_clr  = 5'h00;
		if (wr_take && idx_ok && idx == CIRQ_IDX_MAIN_REQ) begin
			if (pwdata_i[CIRQ_SET_SEL]) begin
				main_set = pwdata_i[6:0];
			end else begin
				main_clr = pwdata_i[6:0];
			end
		end
		if (wr_take && idx_ok && idx == CIRQ_IDX_AUX_REQ) begin
			if (pwdata_i[CIRQ_SET_SEL]) begin
				aux_set = pwdata_i[4:0];
			end else begin
				aux_clr = pwdata_i[4:0];
			end
		end
	end

	// ****************************************************************
	// Combined status and pin level
	// ****************************************************************
	// The pin follows the registered requests, so it trails a request by one cycle.
	assign combined = |(st.main_req & st.main_en[6:0]) ||
		|(st.aux_req & st.aux_en[4:0]);
	assign level    = combined ^ st.main_en[CIRQ_INVERT];

	// ****************************************************************
	// Next state
	// ****************************************************************
	always_comb begin
		next_st = st;
		// Hardware set wins over a software clear in the same cycle.
		next_st.main_req    = (st.main_req & ~main_clr) | main_set | main_hw;
		next_st.aux_req     = (st.aux_req & ~aux_clr) | aux_set | aux_hw;
		next_st.sec_sync    = {st.sec_sync[1:0], secure_signal_input_i};
		next_st.fifo_high_d = events_i.fifo_high_status;
		next_st.fifo_low_d  = events_i.fifo_low_status;
		next_st.field_d     = events_i.field_present;
		if (events_i.auto_anticollision_cmd || events_i.rf_reset) begin
			next_st.det_armed = 1'b1;
		end else if (events_i.mode_detected) begin
			next_st.det_armed = 1'b0;
		end
		if (st.aux_en[CIRQ_DRIVE_SEL]) begin
			next_st.irq_out = level;
			next_st.irq_oe  = 1'b1;
		end else begin
			// Open drain only ever pulls low; a high level releases the pin.
			next_st.irq_out = 1'b0;
			next_st.irq_oe  = !level;
		end
		if (wr_take && idx_ok) begin
			case (idx)
				CIRQ_IDX_MAIN_EN: next_st.main_en = pwdata_i[7:0];
				CIRQ_IDX_AUX_EN:  next_st.aux_en  = pwdata_i[7:0] & CIRQ_AUX_EN_MASK;
				CIRQ_IDX_OPTION:  next_st.receive_clean_only = pwdata_i[0];
				default:          next_st.aux_en  = next_st.aux_en;
			endcase
		end
		next_st.pready  = rd_setup;
		next_st.pslverr = rd_setup && !idx_ok;
		next_st.prdata  = 32'h0000_0000;
		if (rd_setup && !pwrite_i) begin
			case (idx)
				CIRQ_IDX_MAIN_EN:  next_st.prdata[7:0] = st.main_en;
				CIRQ_IDX_AUX_EN:   next_st.prdata[7:0] = st.aux_en;
				CIRQ_IDX_MAIN_REQ: next_st.prdata[6:0] = st.main_req;
				CIRQ_IDX_AUX_REQ:  next_st.prdata[4:0] = st.aux_req;
				CIRQ_IDX_STATUS: begin
					next_st.prdata[CIRQ_STAT_IRQ]   = combined;
					next_st.prdata[CIRQ_STAT_ARMED] = st.det_armed;
				end
				CIRQ_IDX_OPTION:   next_st.prdata[0] = st.receive_clean_only;
				default:           next_st.prdata = 32'h0000_0000;
			endcase
		end
	end

	always_ff @(posedge clk_i or posedge sys_rst_i) begin
		if (sys_rst_i) begin
			st                    <= '0;
			st.main_en            <= CIRQ_MAIN_EN_RST;
			st.aux_en             <= CIRQ_AUX_EN_RST;
			st.main_req           <= CIRQ_MAIN_REQ_RST;
			st.aux_req            <= CIRQ_AUX_REQ_RST;
		end else if (ce_i) begin
			st <= next_st;
		end
	end

	assign prdata_o  = st.prdata;
	assign pready_o  = st.pready;
	assign pslverr_o = st.pslverr;
	assign irq_o     = st.irq_out;
	assign irq_oe_o  = st.irq_oe;

	// ****************************************************************
	// Checks
	// ****************************************************************
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (sys_rst_i);

	sequence main_clear_write_s;
		ce_i && main_wr && !pwdata_i[CIRQ_SET_SEL] &&
			pwdata_i[CIRQ_CNT_ZERO] && !events_i.countdown_zero;
	endsequence

	sequence aux_set_write_s;
		ce_i && aux_wr && pwdata_i[CIRQ_SET_SEL] &&
			pwdata_i[CIRQ_FIELD_ON];
	endsequence

	open_drain_a: assert property (ce_i && !st.aux_en[CIRQ_DRIVE_SEL] |=>
		!irq_o && (irq_oe_o == !$past(level)))
		else $error("open drain pin drive wrong");
	push_pull_a: assert property (ce_i && st.aux_en[CIRQ_DRIVE_SEL] |=>
		irq_oe_o && irq_o == $past(level))
		else $error("push pull pin drive wrong");
	aux_reserved_a: assert property (st.aux_en[6:5] == 2'h0)
		else $error("reserved enable bits set");
	sec_gate_a: assert property (!st.aux_en[CIRQ_SEC_EDGE] && st.main_req == 7'h00 &&
		st.aux_req[3:0] == 4'h0 |-> !combined)
		else $error("disabled secure input edge reached pin");
	mode_gate_a: assert property (st.aux_en[CIRQ_MODE_FOUND] && st.aux_req[CIRQ_MODE_FOUND]
		|-> combined)
		else $error("enabled mode request missing");
	csum_gate_a: assert property (st.aux_en[CIRQ_CSUM_DONE] && st.aux_req[CIRQ_CSUM_DONE]
		|-> combined)
		else $error("enabled checksum request missing");
	field_gate_a: assert property (st.aux_en[1:0] == 2'h0 && st.main_req == 7'h00 &&
		st.aux_req[4:2] == 3'h0 |-> !combined)
		else $error("disabled field request reached pin");
	main_clear_a: assert property (main_clear_write_s |=> !st.main_req[CIRQ_CNT_ZERO])
		else $error("main request not cleared");
	aux_set_a: assert property (aux_set_write_s |=> st.aux_req[CIRQ_FIELD_ON])
		else $error("aux request not set");
	tx_done_a: assert property (ce_i && events_i.tx_last_bit |=> st.main_req[CIRQ_TX_DONE])
		else $error("transmit done lost");
	rx_clean_a: assert property (ce_i && events_i.rx_valid_end && st.receive_clean_only &&
		!events_i.fifo_has_data && !st.main_req[CIRQ_RX_DONE] && !wr_take
		|=> !st.main_req[CIRQ_RX_DONE])
		else $error("receive done set without data");
	idle_unknown_a: assert property (ce_i && events_i.cmd_unknown |=>
		st.main_req[CIRQ_CMD_IDLE])
		else $error("idle request missing");
	sec_edge_a: assert property (ce_i [*3] ##0 $changed(secure_signal_input_i) ##1 ce_i [*2]
		|=> st.aux_req[CIRQ_SEC_EDGE])
		else $error("secure input edge not caught");
	det_stop_a: assert property (ce_i && events_i.mode_detected &&
		!events_i.auto_anticollision_cmd && !events_i.rf_reset |=> !st.det_armed)
		else $error("mode detector kept running");
	field_off_a: assert property (ce_i && st.field_d && !events_i.field_present |=>
		st.aux_req[CIRQ_FIELD_OFF])
		else $error("field off lost");
	pready_a: assert property (ce_i && rd_setup |=> pready_o ##1
		(!pready_o || !$past(ce_i) || $past(rd_setup)))
		else $error("pready timing wrong");
	write_drop_a: assert property (ce_i && wr_take && !idx_ok |=> $stable(st.main_en) &&
		$stable(st.aux_en) && $stable(st.receive_clean_only))
		else $error("unmapped write changed a register");
	slverr_ready_a: assert property (pslverr_o |-> pready_o)
		else $error("error response without ready");
	state_freeze_a: assert property (!ce_i |=> $stable(st))
		else $error("state moved while clock enable low");

	// ****************************************************************
	// Request source checks
	// ****************************************************************
	sequence fifo_high_rise_s;
		ce_i && events_i.fifo_high_status && !st.fifo_high_d;
	endsequence

	sequence fifo_low_rise_s;
		ce_i && events_i.fifo_low_status && !st.fifo_low_d;
	endsequence

	sequence field_rise_s;
		ce_i && events_i.field_present && !st.field_d;
	endsequence

	rx_done_a: assert property (ce_i && events_i.rx_valid_end &&
		(!st.receive_clean_only || events_i.fifo_has_data) |=> st.main_req[CIRQ_RX_DONE])
		else $error("receive done lost");
	idle_self_a: assert property (ce_i && events_i.cmd_self_end |=>
		st.main_req[CIRQ_CMD_IDLE])
		else $error("idle request lost");
	fifo_high_a: assert property (fifo_high_rise_s |=> st.main_req[CIRQ_FIFO_HIGH])
		else $error("high alert request lost");
	high_latch_a: assert property (ce_i && st.main_req[CIRQ_FIFO_HIGH] && !main_wr |=>
		st.main_req[CIRQ_FIFO_HIGH])
		else $error("high alert request dropped");
	fifo_low_a: assert property (fifo_low_rise_s |=>
		st.main_req[CIRQ_FIFO_LOW])
		else $error("low alert request lost");
	low_latch_a: assert property (ce_i && st.main_req[CIRQ_FIFO_LOW] && !main_wr |=>
		st.main_req[CIRQ_FIFO_LOW])
		else $error("low alert request dropped");
	fault_set_a: assert property (ce_i && events_i.error_any |=>
		st.main_req[CIRQ_FAULT])
		else $error("error request lost");
	count_zero_a: assert property (ce_i && events_i.countdown_zero |=>
		st.main_req[CIRQ_CNT_ZERO])
		else $error("timer request lost");
	mode_found_a: assert property (ce_i && events_i.mode_detected && st.det_armed |=>
		st.aux_req[CIRQ_MODE_FOUND])
		else $error("mode request lost");
	det_idle_a: assert property (ce_i && events_i.mode_detected && !st.det_armed &&
		!st.aux_req[CIRQ_MODE_FOUND] && !aux_wr |=> !st.aux_req[CIRQ_MODE_FOUND])
		else $error("mode request from stopped detector");
	det_arm_a: assert property (ce_i && (events_i.auto_anticollision_cmd ||
		events_i.rf_reset) |=> st.det_armed)
		else $error("mode detector not started");
	csum_done_a: assert property (ce_i && events_i.checksum_cmd_active &&
		events_i.checksum_all_done |=> st.aux_req[CIRQ_CSUM_DONE])
		else $error("checksum request lost");
	csum_idle_a: assert property (ce_i && !events_i.checksum_cmd_active &&
		!st.aux_req[CIRQ_CSUM_DONE] && !aux_wr |=> !st.aux_req[CIRQ_CSUM_DONE])
		else $error("checksum request without command");
	field_on_a: assert property (field_rise_s |=> st.aux_req[CIRQ_FIELD_ON])
		else $error("field on lost");

	// ****************************************************************
	// Register access and pin checks
	// ****************************************************************
	main_set_a: assert property (ce_i && main_wr && pwdata_i[CIRQ_SET_SEL] &&
		pwdata_i[CIRQ_TX_DONE] |=> st.main_req[CIRQ_TX_DONE])
		else $error("main request not set");
	main_keep_a: assert property (ce_i && main_wr |=>
		(st.main_req & $past(main_kept)) == $past(main_kept))
		else $error("unwritten main request changed");
	aux_clear_a: assert property (ce_i && aux_wr && !pwdata_i[CIRQ_SET_SEL] &&
		pwdata_i[CIRQ_SEC_EDGE] && !aux_hw[CIRQ_SEC_EDGE]
		|=> !st.aux_req[CIRQ_SEC_EDGE])
		else $error("aux request not cleared");
	aux_keep_a: assert property (ce_i && aux_wr |=>
		(st.aux_req & $past(aux_kept)) == $past(aux_kept))
		else $error("unwritten aux request changed");
	reserved_read_a: assert property (ce_i && rd_setup && !pwrite_i &&
		idx == CIRQ_IDX_AUX_EN |=> prdata_o[6:5] == 2'h0)
		else $error("reserved enable bits read back");
	main_gate_a: assert property ((st.main_req & st.main_en[6:0]) != 7'h00 |->
		combined)
		else $error("enabled main request missing");
	quiet_pin_a: assert property ((st.main_req & st.main_en[6:0]) == 7'h00 &&
		(st.aux_req & st.aux_en[4:0]) == 5'h00 |-> !combined)
		else $error("status set with no enabled request");
	sec_gate_on_a: assert property (st.aux_en[CIRQ_SEC_EDGE] &&
		st.aux_req[CIRQ_SEC_EDGE] |-> combined)
		else $error("enabled secure edge request missing");
	field_gate_on_a: assert property ((st.aux_en[1:0] & st.aux_req[1:0]) != 2'h0 |->
		combined)
		else $error("enabled field request missing");
	released_pin_a: assert property (ce_i && !st.aux_en[CIRQ_DRIVE_SEL] &&
		st.main_en[CIRQ_INVERT] && !combined |=> !irq_oe_o)
		else $error("inverted idle pin not released");

endmodule // cirq_core

/* File: tb/cirq_host_model.sv */
// Host side of the interrupt line: the pull-up on the wire and the level the host sees.
// Assumes the device drives the line only while its output enable is high.
`timescale 1ns/1ps

module cirq_host_model (
	input  wire logic irq_i,
	input  wire logic irq_oe_i,
	output logic      pin_o
);
	// A released open-drain line floats up to the pull-up, never to a stale value.
	assign pin_o = irq_oe_i ? irq_i : 1'b1;
endmodule // cirq_host_model

/* File: tb/tb_cirq_core.sv */
// Self-checking bench of the interrupt request and enable block.
// Assumes an APB slave without wait states is tolerated but not required, one clock domain.
`timescale 1ns/1ps

module tb_cirq_core;
	import cirq_pkg::*;
	logic                   clk_i, sys_rst_i, ce_i, psel_i, penable_i, pwrite_i;
	logic [CIRQ_ADDR_W-1:0] paddr_i;
	logic [31:0]            pwdata_i, prdata_o, rd;
	logic                   pready_o, pslverr_o, irq_o, irq_oe_o, pin, er, sec_in;
	cirq_events_t           events_i;
	logic [7:0]             m_en, a_en, m_req, a_req;
	logic [15:0]            rnd;
	int                     n_fail, samples_checked;

	cirq_core u_cirq_core (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .ce_i(ce_i), .psel_i(psel_i),
		.penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i),
		.prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o), .events_i(events_i),
		.secure_signal_input_i(sec_in), .irq_o(irq_o), .irq_oe_o(irq_oe_o));
	cirq_host_model u_cirq_host_model (.irq_i(irq_o), .irq_oe_i(irq_oe_o), .pin_o(pin));

	initial begin
		clk_i = 1'b0;
		forever #25 clk_i = ~clk_i;
	end

	// ****************************************************************
	// Shared tasks.
	// ****************************************************************
	function automatic logic [15:0] lfsr(input logic [15:0] s);
		return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
	endfunction

	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			n_fail++;
			$display("unexpected %s expected %h seen %h", nm, exp, seen);
		end
	endtask

	task automatic complete_run;
		$display("comparisons %0d mismatches %0d", samples_checked, n_fail);
		if (n_fail == 0 && samples_checked > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask

	// The request is held for up to 16 cycles until pready is seen high, so a slow slave is served as well.
	task automatic apb(input logic wr, input logic [7:0] idx, input logic [7:0] wd);
		int i;
		@(posedge clk_i);
		psel_i <= 1'b1;
		pwrite_i <= wr;
		paddr_i <= CIRQ_ADDR_W'({idx, 2'b00});
		pwdata_i <= {24'h000000, wd};
		@(posedge clk_i);
		penable_i <= 1'b1;
		for (i = 0; i < 16; i++) begin
			@(posedge clk_i);
			if (pready_o === 1'b1) break;
		end
		if (i == 16) begin
			n_fail++;
			$display("unexpected pready_o expected 1 seen 0");
			complete_run();
		end
		rd = prdata_o;
		er = pslverr_o;
		psel_i <= 1'b0;
		penable_i <= 1'b0;
	endtask

	task automatic wreg(input logic [7:0] idx, input logic [7:0] wd);
		apb(1'b1, idx, wd);
		case (idx)
			CIRQ_IDX_MAIN_EN: m_en = wd;
			CIRQ_IDX_AUX_EN: a_en = wd & CIRQ_AUX_EN_MASK;
			CIRQ_IDX_MAIN_REQ: m_req = wd[7] ? (m_req | {1'b0, wd[6:0]}) : (m_req & ~{1'b0, wd[6:0]});
			CIRQ_IDX_AUX_REQ: a_req = wd[7] ? (a_req | {3'h0, wd[4:0]}) : (a_req & ~{3'h0, wd[4:0]});
			default: ;
		endcase
	endtask

	task automatic rchk(input logic [7:0] idx, input logic [7:0] exp);
		apb(1'b0, idx, 8'h00);
		chk("read data", rd, {24'h000000, exp});
		chk("pslverr_o", {31'h0, er}, 32'h0);
	endtask

	task automatic pin_chk;
		logic lvl;
		repeat (3) @(posedge clk_i);
		lvl = (|(m_req[6:0] & m_en[6:0]) | |(a_req[4:0] & a_en[4:0])) ^ m_en[7];
		chk("irq_oe_o", {31'h0, irq_oe_o}, {31'h0, a_en[7] | ~lvl});
		chk("irq_o", {31'h0, irq_o}, {31'h0, a_en[7] & lvl});
		chk("pin level", {31'h0, pin}, {31'h0, lvl});
		rchk(CIRQ_IDX_STATUS, {3'h0, lvl ^ m_en[7], 4'h0});
	endtask

	task automatic fire(input cirq_events_t e, input logic [7:0] idx, input logic [7:0] exp);
		wreg(CIRQ_IDX_MAIN_REQ, 8'h7F);
		wreg(CIRQ_IDX_AUX_REQ, 8'h1F);
		@(posedge clk_i);
		events_i <= e;
		@(posedge clk_i);
		events_i <= '0;
		repeat (3) @(posedge clk_i);
		rchk(idx, exp);
	endtask

	// ****************************************************************
	// Main sequence.
	// ****************************************************************
	initial begin
		ce_i = 1'b1;
		sys_rst_i = 1'b1;
		psel_i = 1'b0;
		penable_i = 1'b0;
		pwrite_i = 1'b0;
		paddr_i = '0;
		pwdata_i = 32'h00000000;
		events_i = '0;
		sec_in = 1'b0;
		n_fail = 0;
		samples_checked = 0;
		rnd = 16'h2EF1;
		m_en = 8'h80;
		a_en = 8'h00;
		m_req = 8'h14;
		a_req = 8'h00;
		repeat (16) @(posedge clk_i);
		sys_rst_i <= 1'b0;
		pin_chk();
		rchk(CIRQ_IDX_AUX_EN, 8'h00);
		ce_i <= 1'b0;
		events_i <= 15'h4000;
		@(posedge clk_i);
		events_i <= '0;
		ce_i <= 1'b1;
		rchk(CIRQ_IDX_MAIN_REQ, 8'h14);
		rchk(CIRQ_IDX_MAIN_EN, 8'h80);
		apb(1'b0, 8'h3F, 8'h00);
		chk("unmapped pslverr_o", {31'h0, er}, 32'h1);
		$display("test reset and unmapped done");
		for (int k = 0; k < 24; k++) begin
			rnd = lfsr(rnd);
			wreg(CIRQ_IDX_MAIN_EN, rnd[7:0]);
			wreg(CIRQ_IDX_AUX_EN, rnd[15:8]);
			rnd = lfsr(rnd);
			wreg(CIRQ_IDX_MAIN_REQ, rnd[7:0]);
			wreg(CIRQ_IDX_AUX_REQ, rnd[15:8]);
			rchk(CIRQ_IDX_MAIN_REQ, m_req);
			rchk(CIRQ_IDX_AUX_REQ, a_req);
			rchk(CIRQ_IDX_AUX_EN, a_en);
			pin_chk();
		end
		$display("test random enables and requests done");
		fire(15'h4000, CIRQ_IDX_MAIN_REQ, 8'h40);
		fire(15'h2000, CIRQ_IDX_MAIN_REQ, 8'h20);
		wreg(CIRQ_IDX_OPTION, 8'h01);
		fire(15'h2000, CIRQ_IDX_MAIN_REQ, 8'h00);
		fire(15'h3000, CIRQ_IDX_MAIN_REQ, 8'h20);
		wreg(CIRQ_IDX_OPTION, 8'h00);
		fire(15'h0800, CIRQ_IDX_MAIN_REQ, 8'h10);
		fire(15'h0400, CIRQ_IDX_MAIN_REQ, 8'h10);
		fire(15'h0200, CIRQ_IDX_MAIN_REQ, 8'h08);
		fire(15'h0100, CIRQ_IDX_MAIN_REQ, 8'h04);
		fire(15'h0080, CIRQ_IDX_MAIN_REQ, 8'h02);
		fire(15'h0040, CIRQ_IDX_MAIN_REQ, 8'h01);
		fire(15'h0020, CIRQ_IDX_AUX_REQ, 8'h00);
		fire(15'h0010, CIRQ_IDX_AUX_REQ, 8'h00);
		fire(15'h0020, CIRQ_IDX_AUX_REQ, 8'h08);
		fire(15'h0020, CIRQ_IDX_AUX_REQ, 8'h00);
		fire(15'h0008, CIRQ_IDX_AUX_REQ, 8'h00);
		fire(15'h0020, CIRQ_IDX_AUX_REQ, 8'h08);
		fire(15'h0006, CIRQ_IDX_AUX_REQ, 8'h04);
		fire(15'h0002, CIRQ_IDX_AUX_REQ, 8'h00);
		fire(15'h0001, CIRQ_IDX_AUX_REQ, 8'h03);
		$display("test event sources done");
		for (int k = 0; k < 2; k++) begin
			wreg(CIRQ_IDX_AUX_REQ, 8'h1F);
			sec_in <= ~sec_in;
			repeat (6) @(posedge clk_i);
			rchk(CIRQ_IDX_AUX_REQ, 8'h10);
		end
		$display("test secure input edges done");
		complete_run();
	end
endmodule // tb_cirq_core
